/* File: lsr_defs.svh */
`ifndef LSR_DEFS_SVH
`define LSR_DEFS_SVH

// Register map (byte addresses on the 5-bit register port)
`define LSR_ADDR_MEM_LAST 5'h0f
`define LSR_ADDR_CMD 5'h10
`define LSR_ADDR_BLINK 5'h11
`define LSR_ADDR_SUPPLY 5'h12
`define LSR_ADDR_BASECLK 5'h13
`define LSR_ADDR_FPEN0 5'h14
`define LSR_ADDR_FPEN3 5'h17
`define LSR_ADDR_STATUS 5'h18

// display_command_reg fields
`define LSR_CMD_EN_BIT 0
`define LSR_CMD_BANK_BIT 1
`define LSR_CMD_CLR_BIT 2
`define LSR_CMD_BLANK_BIT 3

// blink_control_reg fields
`define LSR_BLK_ON_BIT 0
`define LSR_BLK_WHOLE_BIT 1
`define LSR_BLK_RATE_LSB 2

// supply_config_reg fields
`define LSR_SUP_FIELD_LSB 0
`define LSR_SUP_BYPASS_BIT 2
`define LSR_SUP_CP_BIT 3

// Reset values
`define LSR_RST_CMD 8'h00
`define LSR_RST_BLINK 8'h00
`define LSR_RST_SUPPLY 8'h00
`define LSR_RST_BASECLK 3'h0

// Timing
`define LSR_SYS_CLK_HZ 50000000
`define LSR_LCD_CLK_HZ 32768
`define LSR_BASE_DIV_MIN 16
`define LSR_STARTUP_TICKS 16
`define LSR_BLINK_DIV_EXP_MIN 5

`endif

/* File: lsr_pkg.sv */
package lsr_pkg;
  typedef logic [4:0] lsr_addr_t;
  typedef logic [7:0] lsr_byte_t;
  typedef enum logic [1:0] {
    LSR_SUP_INT_VLL2,
    LSR_SUP_INT_VLL3,
    LSR_SUP_EXT_VLCD,
    LSR_SUP_EXT_BIAS
  } lsr_supply_t;
endpackage

/* File: lsr_ctrl.sv */
// What this block does
// - Each memory bit maps to exactly one panel segment.
// - Bank select 0 reaches on/off data, 1 reaches blink enables.
// - Enabled display and frontplane: stored 1 drives on, 0 drives off.
// - Segment memory is dual ported and usable as plain storage when disabled.
// - Touching the display enable bit leaves memory contents alone.
// - Memory is not initialised on reset; contents undefined until written.
// - Clear zeroes only the bank named by the bank bit in the same write.
// - Blank forces all segments off while timing keeps running.
// - Touching the blank bit leaves memory contents alone.
// - Panel blinks at the 3-bit rate while the blink bit is 1.
// - Blink start or stop waits for the next frame start.
// - Whole-panel select blinks all segments, else only enabled ones.
// - Per-segment blink needs the bit set in both banks.
// - Each memory byte holds two frontplanes, one bit per backplane.
// - Blink divider is base clock over 2 to the 5 plus rate.
// - Two-bit supply field decodes into power switch controls.
// - Buffer enabled only with bypass clear and external switch set.
// - First 16 timebase cycles after pump enable keep the panel drive enable off.
// - Codes 10 and 11 select external supply, 00 and 01 internal.
// - Code 10 asserts the external switch and no other switch.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "lsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module lsr_ctrl #(
  parameter int unsigned NUM_FP = 32,
  parameter int unsigned NUM_BP = 4,
  parameter int unsigned FRAME_TICKS = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire lsr_pkg::lsr_addr_t addr_in,
  input wire lsr_pkg::lsr_byte_t wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output lsr_pkg::lsr_byte_t rd_data_out,
  // Panel side
  output logic [NUM_FP*NUM_BP-1:0] seg_on_out,
  output logic panel_drive_en_out,
  output logic blink_phase_out,
  // Power switch controls
  output logic int_sw_vll2_out,
  output logic int_sw_vll3_out,
  output logic ext_supply_switch_out,
  output logic buffer_en_out,
  output logic charge_pump_en_out
);
  import lsr_pkg::*;

  localparam int unsigned NUM_SEG = NUM_FP * NUM_BP;
  localparam int unsigned MEM_BYTES = NUM_SEG / 8;
  localparam int unsigned PRESCALE = `LSR_SYS_CLK_HZ / `LSR_LCD_CLK_HZ;
  localparam logic [10:0] PRESCALE_LAST = 11'(PRESCALE - 1);
  localparam logic [4:0] STARTUP_LOAD = 5'(`LSR_STARTUP_TICKS);
  localparam logic [1:0] FRAME_LAST = 2'(FRAME_TICKS - 1);

  // Half of a blink period in base ticks: 2^(5+rate)/2
  function automatic logic [11:0] blink_half(input logic [2:0] rate);
    blink_half = 12'(`LSR_BLINK_DIV_EXP_MIN'(0)) | (12'h001 << (`LSR_BLINK_DIV_EXP_MIN - 1 + rate));
  endfunction

  // Byte view of a flattened bank
  function automatic lsr_byte_t bank_byte(input logic [NUM_SEG-1:0] bank, input logic [3:0] idx);
    bank_byte = bank[idx*8 +: 8];
  endfunction

  // Segment memory, both banks; no reset on purpose
  logic [NUM_SEG-1:0] onoff_mem;
  logic [NUM_SEG-1:0] blinken_mem;

  // Control registers
  logic display_enable_bit_reg;
  logic segment_bank_select_reg;
  logic blank_reg;
  logic blink_bit_reg;
  logic whole_panel_blink_select_reg;
  logic [2:0] blink_rate_field_reg;
  logic [1:0] supply_source_field_reg;
  logic buffer_bypass_bit_reg;
  logic charge_pump_on_bit_reg;
  logic [2:0] base_clock_divider_field_reg;
  logic [NUM_FP-1:0] frontplane_enables_reg;

  // Timing state
  logic [10:0] prescale_reg;
  logic [10:0] base_cnt_reg;
  logic [1:0] frame_cnt_reg;
  logic blink_active_reg;
  logic [11:0] blink_cnt_reg;
  logic blink_off_reg;
  logic cp_prev_reg;
  logic [4:0] startup_cnt_reg;

  // Address decode
  wire mem_hit = (addr_in <= `LSR_ADDR_MEM_LAST);
  wire cmd_hit = (addr_in == `LSR_ADDR_CMD);
  wire blink_hit = (addr_in == `LSR_ADDR_BLINK);
  wire supply_hit = (addr_in == `LSR_ADDR_SUPPLY);
  wire baseclk_hit = (addr_in == `LSR_ADDR_BASECLK);
  wire fpen_hit = (addr_in >= `LSR_ADDR_FPEN0) && (addr_in <= `LSR_ADDR_FPEN3);
  wire status_hit = (addr_in == `LSR_ADDR_STATUS);
  wire [1:0] fpen_idx = addr_in[1:0];
  wire [3:0] mem_idx = addr_in[3:0];

  wire cmd_wr = wr_en_in && cmd_hit;
  wire clear_req = cmd_wr && wr_data_in[`LSR_CMD_CLR_BIT];
  // Clear acts on the bank named in the same write
  wire clear_bank = wr_data_in[`LSR_CMD_BANK_BIT];
  wire mem_wr = wr_en_in && mem_hit;

  // Timebase: lcd clock enable, then waveform base tick
  wire lcd_tick = (prescale_reg == PRESCALE_LAST);
  wire [10:0] base_last = 11'((`LSR_BASE_DIV_MIN << base_clock_divider_field_reg) - 1);
  wire base_tick = lcd_tick && (base_cnt_reg == base_last);
  wire frame_start = base_tick && (frame_cnt_reg == FRAME_LAST);
  wire [11:0] half_last = blink_half(blink_rate_field_reg) - 12'h001;
  wire blink_toggle = blink_active_reg && base_tick && (blink_cnt_reg == half_last);

  // Segment composition
  logic [NUM_SEG-1:0] fp_mask;
  always_comb begin
    for (int i = 0; i < NUM_SEG; i++) begin
      fp_mask[i] = frontplane_enables_reg[i / NUM_BP];
    end
  end
  wire [NUM_SEG-1:0] blink_sel = whole_panel_blink_select_reg ? {NUM_SEG{1'b1}} : blinken_mem;
  wire [NUM_SEG-1:0] blink_kill = (blink_active_reg && blink_off_reg) ? blink_sel : '0;
  wire show = display_enable_bit_reg && !blank_reg;
  wire [NUM_SEG-1:0] seg_next = show ? (onoff_mem & fp_mask & ~blink_kill) : '0;
  wire startup_busy = (startup_cnt_reg != 5'h00);
  wire panel_next = display_enable_bit_reg && !startup_busy;

  // Supply decode
  wire lsr_supply_t sup = lsr_supply_t'(supply_source_field_reg);
  wire sw2_next = (sup == LSR_SUP_INT_VLL2);
  wire sw3_next = (sup == LSR_SUP_INT_VLL3);
  wire ext_next = (sup == LSR_SUP_EXT_VLCD);
  wire buf_next = !buffer_bypass_bit_reg && ext_next;

  // Readback
  wire [7:0] status_byte = {5'h00, startup_busy, blink_off_reg, blink_active_reg};
  wire [7:0] cmd_byte = {4'h0, blank_reg, 1'b0, segment_bank_select_reg, display_enable_bit_reg};
  wire [7:0] blink_byte = {3'h0, blink_rate_field_reg, whole_panel_blink_select_reg,
                           blink_bit_reg};
  wire [7:0] supply_byte = {4'h0, charge_pump_on_bit_reg, buffer_bypass_bit_reg,
                            supply_source_field_reg};
  wire [7:0] mem_byte = segment_bank_select_reg ? bank_byte(blinken_mem, mem_idx)
                                                : bank_byte(onoff_mem, mem_idx);
  logic [7:0] rd_next;
  always_comb begin
    if (mem_hit) begin
      rd_next = mem_byte;
    end else if (cmd_hit) begin
      rd_next = cmd_byte;
    end else if (blink_hit) begin
      rd_next = blink_byte;
    end else if (supply_hit) begin
      rd_next = supply_byte;
    end else if (baseclk_hit) begin
      rd_next = {5'h00, base_clock_divider_field_reg};
    end else if (fpen_hit) begin
      rd_next = frontplane_enables_reg[fpen_idx*8 +: 8];
    end else if (status_hit) begin
      rd_next = status_byte;
    end else begin
      rd_next = 8'h00;
    end
  end

  // Memory writes; only data writes and clear touch it
  always_ff @(posedge sys_clk_in) begin
    if (clear_req && !clear_bank) begin
      onoff_mem <= '0;
    end else if (mem_wr && !segment_bank_select_reg) begin
      onoff_mem[mem_idx*8 +: 8] <= wr_data_in;
    end
    if (clear_req && clear_bank) begin
      blinken_mem <= '0;
    end else if (mem_wr && segment_bank_select_reg) begin
      blinken_mem[mem_idx*8 +: 8] <= wr_data_in;
    end
  end

  // Control registers; command writes reach the memory only through the clear bit
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {blank_reg, segment_bank_select_reg, display_enable_bit_reg} <= 3'h0;
      {blink_rate_field_reg, whole_panel_blink_select_reg, blink_bit_reg} <= 5'h00;
      {charge_pump_on_bit_reg, buffer_bypass_bit_reg, supply_source_field_reg} <= 4'h0;
      base_clock_divider_field_reg <= `LSR_RST_BASECLK;
      frontplane_enables_reg <= '0;
    end else if (wr_en_in) begin
      if (cmd_hit) begin
        display_enable_bit_reg <= wr_data_in[`LSR_CMD_EN_BIT];
        segment_bank_select_reg <= wr_data_in[`LSR_CMD_BANK_BIT];
        blank_reg <= wr_data_in[`LSR_CMD_BLANK_BIT];
      end else if (blink_hit) begin
        blink_bit_reg <= wr_data_in[`LSR_BLK_ON_BIT];
        whole_panel_blink_select_reg <= wr_data_in[`LSR_BLK_WHOLE_BIT];
        blink_rate_field_reg <= wr_data_in[`LSR_BLK_RATE_LSB +: 3];
      end else if (supply_hit) begin
        supply_source_field_reg <= wr_data_in[`LSR_SUP_FIELD_LSB +: 2];
        buffer_bypass_bit_reg <= wr_data_in[`LSR_SUP_BYPASS_BIT];
        charge_pump_on_bit_reg <= wr_data_in[`LSR_SUP_CP_BIT];
      end else if (baseclk_hit) begin
        base_clock_divider_field_reg <= wr_data_in[2:0];
      end else if (fpen_hit) begin
        frontplane_enables_reg[fpen_idx*8 +: 8] <= wr_data_in;
      end
    end
  end

  // Timebase keeps running under blank
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prescale_reg <= 11'h000;
      base_cnt_reg <= 11'h000;
      frame_cnt_reg <= 2'h0;
    end else begin
      prescale_reg <= lcd_tick ? 11'h000 : prescale_reg + 11'h001;
      if (lcd_tick) begin
        base_cnt_reg <= (base_cnt_reg >= base_last) ? 11'h000 : base_cnt_reg + 11'h001;
      end
      if (base_tick) begin
        frame_cnt_reg <= (frame_cnt_reg == FRAME_LAST) ? 2'h0 : frame_cnt_reg + 2'h1;
      end
    end
  end

  // Blink engine
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      blink_active_reg <= 1'b0;
      blink_cnt_reg <= 12'h000;
      blink_off_reg <= 1'b0;
    end else begin
      if (frame_start) begin
        blink_active_reg <= blink_bit_reg;
      end
      if (!blink_active_reg) begin
        blink_cnt_reg <= 12'h000;
        blink_off_reg <= 1'b0;
      end else if (blink_toggle) begin
        blink_cnt_reg <= 12'h000;
        blink_off_reg <= !blink_off_reg;
      end else if (base_tick) begin
        // A rate lowered mid-phase wraps here rather than running on
        blink_cnt_reg <= (blink_cnt_reg > half_last) ? 12'h000 : blink_cnt_reg + 12'h001;
      end
    end
  end

  // Startup blanking after charge pump enable
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cp_prev_reg <= 1'b0;
      startup_cnt_reg <= 5'h00;
    end else begin
      cp_prev_reg <= charge_pump_on_bit_reg;
      if (charge_pump_on_bit_reg && !cp_prev_reg) begin
        startup_cnt_reg <= STARTUP_LOAD;
      end else if (startup_busy && base_tick) begin
        startup_cnt_reg <= startup_cnt_reg - 5'h01;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 8'h00;
      seg_on_out <= '0;
      panel_drive_en_out <= 1'b0;
      blink_phase_out <= 1'b0;
      {int_sw_vll2_out, int_sw_vll3_out, ext_supply_switch_out} <= 3'h0;
      buffer_en_out <= 1'b0;
      charge_pump_en_out <= 1'b0;
    end else begin
      rd_data_out <= rd_en_in ? rd_next : 8'h00;
      seg_on_out <= seg_next;
      panel_drive_en_out <= panel_next;
      blink_phase_out <= blink_off_reg;
      int_sw_vll2_out <= sw2_next;
      int_sw_vll3_out <= sw3_next;
      ext_supply_switch_out <= ext_next;
      buffer_en_out <= buf_next;
      charge_pump_en_out <= charge_pump_on_bit_reg;
    end
  end

  AST_BUF_EN: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    buffer_en_out |-> $past(supply_source_field_reg == 2'b10 && !buffer_bypass_bit_reg))
    else $error("buffer enabled without external switch and clear bypass");

  AST_EXT_ONLY: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ext_supply_switch_out |-> !int_sw_vll2_out && !int_sw_vll3_out)
    else $error("external switch not alone");

  AST_EXT_CODE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    supply_source_field_reg[1] |=> !int_sw_vll2_out && !int_sw_vll3_out)
    else $error("internal switch on with external code");

  AST_STARTUP_LOAD: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(charge_pump_on_bit_reg) |=> startup_cnt_reg == 5'h10)
    else $error("startup count not loaded to 16");

  AST_STARTUP_OFF: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    startup_cnt_reg != 5'h00 |=> !panel_drive_en_out)
    else $error("panel driven during startup blanking");

  AST_BLANK: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    blank_reg |=> seg_on_out == '0)
    else $error("segment on while blanked");

  AST_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clear_req && !clear_bank |=> onoff_mem == '0 && $stable(blinken_mem))
    else $error("clear hit the wrong bank");

  AST_DEFER: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $changed(blink_active_reg) |-> $past(frame_start))
    else $error("blink state changed outside frame start");

  AST_HALF: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    blink_active_reg && $changed(blink_off_reg) |-> $past(blink_cnt_reg) == $past(half_last))
    else $error("blink phase length wrong");

  AST_MEM_READ: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    rd_en_in && mem_hit && !segment_bank_select_reg |=> rd_data_out == $past(mem_byte))
    else $error("memory readback mismatch");

endmodule

`default_nettype wire

/* File: lsr_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lsr_panel_model #(
  parameter int unsigned NUM_SEG = 128
) (
  // Drive from the controller
  input wire logic [NUM_SEG-1:0] seg_on_in,
  input wire logic panel_drive_en_in,
  // What a viewer sees
  output logic [NUM_SEG-1:0] lit_out
);
  // Undriven electrodes float, so nothing can show
  assign lit_out = panel_drive_en_in ? seg_on_in : '0;
endmodule

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import lsr_pkg::*;
  logic sys_clk_in;
  logic reset_n_in;
  lsr_addr_t addr_in;
  lsr_byte_t wr_data_in;
  logic wr_en_in;
  logic rd_en_in;
  lsr_byte_t rd_data_out;
  logic [127:0] seg_on_out;
  logic [127:0] lit;
  logic panel_drive_en_out;
  logic blink_phase_out;
  logic vll2_sw;
  logic vll3_sw;
  logic ext_sw;
  logic buf_en;
  logic cp_en;
  int mismatches;
  int check_count;

  lsr_ctrl DUT (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .seg_on_out(seg_on_out),
    .panel_drive_en_out(panel_drive_en_out), .blink_phase_out(blink_phase_out),
    .int_sw_vll2_out(vll2_sw), .int_sw_vll3_out(vll3_sw),
    .ext_supply_switch_out(ext_sw), .buffer_en_out(buf_en), .charge_pump_en_out(cp_en)
  );

  lsr_panel_model panel (
    .seg_on_in(seg_on_out), .panel_drive_en_in(panel_drive_en_out), .lit_out(lit)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_byte(input string name, input lsr_byte_t exp, input lsr_byte_t got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic reg_write(input lsr_addr_t a, input lsr_byte_t d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_en_in <= 1'b0;
  endtask

  task automatic read_check(input lsr_addr_t a, input lsr_byte_t exp);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_en_in <= 1'b0;
    #1;
    check_byte("rd_data", exp, rd_data_out);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // Generous margin over the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches++;
    $display("MISMATCH watchdog expected done seen hang");
    print_verdict();
  end

  initial begin
    lsr_byte_t e;
    reset_n_in = 1'b0;
    addr_in = '0;
    wr_data_in = '0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    waitc(1);
    check_bit("drive_en", 1'b0, panel_drive_en_out);
    for (int a = 16; a < 20; a++) read_check(lsr_addr_t'(a), 8'h00);
    reg_write(5'h19, 8'hff);
    read_check(5'h19, 8'h00);
    $display("Test reset done");
    // Distinct patterns per bank; display off so memory is plain storage
    for (int k = 0; k < 16; k++) reg_write(lsr_addr_t'(k), lsr_byte_t'(8'h30 + k));
    reg_write(5'h10, 8'h02);
    for (int k = 0; k < 16; k++) reg_write(lsr_addr_t'(k), lsr_byte_t'(8'hc0 + k));
    for (int k = 0; k < 16; k++) read_check(lsr_addr_t'(k), lsr_byte_t'(8'hc0 + k));
    reg_write(5'h10, 8'h00);
    for (int k = 0; k < 16; k++) read_check(lsr_addr_t'(k), lsr_byte_t'(8'h30 + k));
    $display("Test banks done");
    reg_write(5'h14, 8'hfe);
    for (int a = 21; a < 24; a++) reg_write(lsr_addr_t'(a), 8'hff);
    reg_write(5'h10, 8'h01);
    read_check(5'h02, 8'h32);
    waitc(3);
    check_bit("drive_en", 1'b1, panel_drive_en_out);
    for (int k = 0; k < 16; k++) begin
      e = lsr_byte_t'(8'h30 + k) & ((k == 0) ? 8'hf0 : 8'hff);
      check_byte("seg", e, seg_on_out[8*k +: 8]);
      check_byte("lit", e, lit[8*k +: 8]);
    end
    $display("Test display done");
    reg_write(5'h10, 8'h09);
    waitc(3);
    check_bit("seg_any", 1'b0, |seg_on_out);
    read_check(5'h03, 8'h33);
    reg_write(5'h10, 8'h01);
    $display("Test blank done");
    // Blinking may only start at a frame boundary, far beyond this span
    reg_write(5'h11, 8'h03);
    waitc(200);
    check_bit("blink_phase", 1'b0, blink_phase_out);
    check_byte("seg", 8'h31, seg_on_out[15:8]);
    read_check(5'h18, 8'h00);
    reg_write(5'h11, 8'h00);
    $display("Test blink defer done");
    reg_write(5'h10, 8'h06);
    read_check(5'h10, 8'h02);
    for (int k = 0; k < 16; k++) read_check(lsr_addr_t'(k), 8'h00);
    reg_write(5'h10, 8'h00);
    for (int k = 0; k < 16; k++) read_check(lsr_addr_t'(k), lsr_byte_t'(8'h30 + k));
    reg_write(5'h10, 8'h05);
    waitc(3);
    check_bit("seg_any", 1'b0, |seg_on_out);
    read_check(5'h05, 8'h00);
    $display("Test clear done");
    for (int c = 0; c < 4; c++) begin
      for (int b = 0; b < 2; b++) begin
        reg_write(5'h12, lsr_byte_t'(b * 4 + c));
        waitc(2);
        check_bit("vll2_sw", c == 0, vll2_sw);
        check_bit("vll3_sw", c == 1, vll3_sw);
        check_bit("ext_sw", c == 2, ext_sw);
        check_bit("buf_en", (c == 2) && (b == 0), buf_en);
      end
    end
    $display("Test supply done");
    reg_write(5'h10, 8'h01);
    reg_write(5'h12, 8'h00);
    waitc(3);
    check_bit("drive_en", 1'b1, panel_drive_en_out);
    reg_write(5'h12, 8'h08);
    waitc(3);
    check_bit("cp_en", 1'b1, cp_en);
    check_bit("drive_en", 1'b0, panel_drive_en_out);
    read_check(5'h18, 8'h04);
    waitc(2000);
    check_bit("drive_en", 1'b0, panel_drive_en_out);
    check_bit("lit_any", 1'b0, |lit);
    $display("Test startup blanking done");
    print_verdict();
  end
endmodule

`default_nettype wire
